// ---- iatp_map.svh ----
`ifndef IATP_MAP_SVH
`define IATP_MAP_SVH

// Data space addresses of the mapped registers
`define IATP_ADDR_PORT_A   8'h00
`define IATP_ADDR_PTR_A    8'h01
`define IATP_ADDR_PORT_B   8'h02
`define IATP_ADDR_ALU_STAT 8'h03
`define IATP_ADDR_BANK_SEL 8'h04
`define IATP_ADDR_TPTR_LO  8'h05
`define IATP_ADDR_TPTR_HI  8'h06
`define IATP_ADDR_PTR_B    8'h08
// First address backed by data RAM, and first banked address
`define IATP_ADDR_RAM_LO   8'h10
`define IATP_ADDR_BANK_LO  8'h20

// Status register fields
`define IATP_ALU_ZERO_BIT  2
`define IATP_MODE_A_LSB    4
`define IATP_MODE_B_LSB    6

// Pointer mode codes (upper bit set means hold)
`define IATP_MODE_DEC      2'h0
`define IATP_MODE_INC      2'h1

// Reset values
`define IATP_RST_BYTE      8'h00
`define IATP_RST_ALU       8'hF0
`define IATP_RST_WORD      16'h0000

`endif

// ---- iatp_pkg.sv ----
package iatp_pkg;

  // Table and latch operations issued by the instruction decoder
  typedef enum logic [2:0] {
    IATP_TOP_NONE,
    IATP_TOP_TABLE_READ,
    IATP_TOP_TABLE_WRITE,
    IATP_TOP_LATCH_READ,
    IATP_TOP_LATCH_WRITE
  } iatp_tbl_op_type;

  // Whole state of the block except the data RAM
  typedef struct packed {
    logic [7:0]  data_pointer_a;
    logic [7:0]  data_pointer_b;
    logic [7:0]  alu_status_reg;
    logic [7:0]  bank_select_reg;
    logic [15:0] table_pointer;
    logic [15:0] table_latch;
    logic [7:0]  rd_data;
    logic [7:0]  tbl_byte;
    logic        pm_rd;
    logic        pm_wr;
    logic [15:0] pm_addr;
    logic [15:0] pm_wdata;
    logic        capture_pm;
    logic        capture_high;
  } iatp_state_type;

endpackage : iatp_pkg

// ---- iatp_core.sv ----
`include "iatp_map.svh"

// Functional notes
// - Two indirect ports without storage, each paired with one pointer.
// - Port access really reaches the location its pointer holds.
// - Pointers are 8 bits and reach all 256 data addresses.
// - Banked locations take their bank from the bank select register.
// - Indirect read of an indirect port returns zero, sets zero flag.
// - Indirect write of an indirect port stores nothing; its pointer still steps.
// - Two mode bits per pointer choose decrement, increment or hold.
// - Mode bits sit in status: upper pair pointer b, lower pair a.
// - Pointer stepping never touches any status flag.
// - Pointer at zero: read gives zero and zero flag, write is void.
// - Indirect moves finish in one cycle, like direct ones.
// - Low and high table pointer bytes form a 16-bit pointer.
// - Table read and write use the table pointer as word address.
// - Two-byte table latch, not visible in any address space.
// - Every program and data transfer passes through the latch.
module iatp_core
  import iatp_pkg::*;
(
  // Clock and reset
  input  wire logic            i_core_clk,
  input  wire logic            i_reset_n,
  // Data space access port
  input  wire logic [7:0]      i_addr,
  input  wire logic [7:0]      i_wr_data,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic      [7:0]      o_rd_data,
  // Table and latch operations
  input  wire iatp_tbl_op_type i_tbl_op,
  input  wire logic            i_tbl_high,
  input  wire logic            i_tbl_incr,
  input  wire logic [7:0]      i_tbl_byte,
  output logic      [7:0]      o_tbl_byte,
  // Program memory port
  output logic                 o_pm_rd,
  output logic                 o_pm_wr,
  output logic      [15:0]     o_pm_addr,
  output logic      [15:0]     o_pm_wdata,
  input  wire logic [15:0]     i_pm_rdata,
  // Status view
  output logic      [7:0]      o_alu_status
);

  iatp_state_type state;
  iatp_state_type next_state;

  // Data RAM: two banks of the full byte range, bank 0 for unbanked space
  logic [7:0] ram [0:511];

  logic        access;
  logic        via_a;
  logic        via_b;
  logic [7:0]  eff_addr;
  logic        self_hit;
  logic        eff_bank;
  logic [8:0]  ram_index;
  logic        ram_hit;
  logic        ram_we;
  logic [7:0]  read_value;
  logic [1:0]  mode_a;
  logic [1:0]  mode_b;

  // Address resolution through the port and pointer pairs
  always_comb begin
    access = i_wr || i_rd;
    via_a  = i_addr == `IATP_ADDR_PORT_A;
    via_b  = i_addr == `IATP_ADDR_PORT_B;
    if (via_a) begin
      eff_addr = state.data_pointer_a;
    end else if (via_b) begin
      eff_addr = state.data_pointer_b;
    end else begin
      eff_addr = i_addr;
    end
    self_hit = (via_a || via_b) &&
               (eff_addr == `IATP_ADDR_PORT_A ||
                eff_addr == `IATP_ADDR_PORT_B);
    eff_bank  = (eff_addr >= `IATP_ADDR_BANK_LO) &&
                state.bank_select_reg[0];
    ram_index = {eff_bank, eff_addr};
    ram_hit   = eff_addr >= `IATP_ADDR_RAM_LO;
    ram_we    = i_wr && ram_hit && !self_hit;
  end

  // Read multiplexer over registers and RAM
  always_comb begin
    read_value = 8'h00;
    if (ram_hit) begin
      read_value = ram[ram_index];
    end else begin
      unique case (eff_addr)
        `IATP_ADDR_PTR_A:    read_value = state.data_pointer_a;
        `IATP_ADDR_PTR_B:    read_value = state.data_pointer_b;
        `IATP_ADDR_ALU_STAT: read_value = state.alu_status_reg;
        `IATP_ADDR_BANK_SEL: read_value = state.bank_select_reg;
        `IATP_ADDR_TPTR_LO:  read_value = state.table_pointer[7:0];
        `IATP_ADDR_TPTR_HI:  read_value = state.table_pointer[15:8];
        default:             read_value = 8'h00;
      endcase
    end
    if (self_hit) begin
      read_value = 8'h00;
    end
  end

  assign mode_a = state.alu_status_reg[`IATP_MODE_A_LSB +: 2];
  assign mode_b = state.alu_status_reg[`IATP_MODE_B_LSB +: 2];

  // Next state of every register
  always_comb begin
    next_state            = state;
    next_state.rd_data    = 8'h00;
    next_state.pm_rd      = 1'b0;
    next_state.pm_wr      = 1'b0;
    next_state.capture_pm = 1'b0;

    if (access && via_a && !mode_a[1]) begin
      next_state.data_pointer_a = (mode_a == `IATP_MODE_INC) ?
        state.data_pointer_a + 8'h01 : state.data_pointer_a - 8'h01;
    end
    if (access && via_b && !mode_b[1]) begin
      next_state.data_pointer_b = (mode_b == `IATP_MODE_INC) ?
        state.data_pointer_b + 8'h01 : state.data_pointer_b - 8'h01;
    end

    if (i_rd) begin
      next_state.rd_data = read_value;
    end

    if (i_rd && self_hit) begin
      next_state.alu_status_reg[`IATP_ALU_ZERO_BIT] = 1'b1;
    end

    // writes to the ports are dropped; a write beats a data pointer step but not a table pointer step
    if (i_wr && !self_hit && !ram_hit) begin
      unique case (eff_addr)
        `IATP_ADDR_PTR_A:    next_state.data_pointer_a = i_wr_data;
        `IATP_ADDR_PTR_B:    next_state.data_pointer_b = i_wr_data;
        `IATP_ADDR_ALU_STAT: next_state.alu_status_reg = i_wr_data;
        `IATP_ADDR_BANK_SEL: next_state.bank_select_reg = i_wr_data;
        `IATP_ADDR_TPTR_LO:  next_state.table_pointer[7:0] = i_wr_data;
        `IATP_ADDR_TPTR_HI:  next_state.table_pointer[15:8] = i_wr_data;
        default:             next_state.bank_select_reg =
                               state.bank_select_reg;
      endcase
    end

    // Program memory word captured one cycle after a table read
    // latch holds fetched word
    if (state.capture_pm) begin
      next_state.table_latch = i_pm_rdata;
    end

    unique case (i_tbl_op)
      IATP_TOP_TABLE_READ: begin
        next_state.pm_rd        = 1'b1;
        next_state.pm_addr      = state.table_pointer;
        next_state.capture_pm   = 1'b1;
        next_state.capture_high = i_tbl_high;
        next_state.tbl_byte     = i_tbl_high ?
          state.table_latch[15:8] : state.table_latch[7:0];
      end
      IATP_TOP_TABLE_WRITE: begin
        next_state.pm_wr   = 1'b1;
        next_state.pm_addr = state.table_pointer;
        if (i_tbl_high) begin
          next_state.table_latch[15:8] = i_tbl_byte;
          next_state.pm_wdata = {i_tbl_byte, state.table_latch[7:0]};
        end else begin
          next_state.table_latch[7:0] = i_tbl_byte;
          next_state.pm_wdata = {state.table_latch[15:8], i_tbl_byte};
        end
      end
      IATP_TOP_LATCH_READ: begin
        next_state.tbl_byte = i_tbl_high ?
          state.table_latch[15:8] : state.table_latch[7:0];
      end
      IATP_TOP_LATCH_WRITE: begin
        if (i_tbl_high) begin
          next_state.table_latch[15:8] = i_tbl_byte;
        end else begin
          next_state.table_latch[7:0] = i_tbl_byte;
        end
      end
      default: begin
        next_state.tbl_byte = state.tbl_byte;
      end
    endcase

    // Optional table pointer step after a table transfer
    if (i_tbl_incr && (i_tbl_op == IATP_TOP_TABLE_READ ||
                       i_tbl_op == IATP_TOP_TABLE_WRITE)) begin
      next_state.table_pointer = state.table_pointer + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state                <= '0;
      state.alu_status_reg <= `IATP_RST_ALU;
    end else begin
      state <= next_state;
    end
  end

  // RAM write port, no reset on storage
  always_ff @(posedge i_core_clk) begin
    if (ram_we) begin
      ram[ram_index] <= i_wr_data;
    end
  end

  // Outputs from flip-flops
  assign o_rd_data    = state.rd_data;
  assign o_tbl_byte   = state.tbl_byte;
  assign o_pm_rd      = state.pm_rd;
  assign o_pm_wr      = state.pm_wr;
  assign o_pm_addr    = state.pm_addr;
  assign o_pm_wdata   = state.pm_wdata;
  assign o_alu_status = state.alu_status_reg;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  // Stepping and flags
  // increment on read
  step_inc_a: assert property (
    i_rd && via_a && mode_a == 2'b01 && eff_addr != `IATP_ADDR_PTR_A
    |=> state.data_pointer_a == $past(state.data_pointer_a) + 8'h01)
    else $error("pointer a did not increment");
  step_dec_b_a: assert property (
    i_rd && via_b && mode_b == 2'b00 && eff_addr != `IATP_ADDR_PTR_B
    |=> state.data_pointer_b == $past(state.data_pointer_b) - 8'h01)
    else $error("pointer b did not decrement");
  hold_mode_a: assert property (
    access && via_a && mode_a[1] && i_rd
    |=> $stable(state.data_pointer_a))
    else $error("pointer a moved in hold mode");
  step_no_flag_a: assert property (
    i_rd && (via_a || via_b) && !self_hit
    |=> $stable(state.alu_status_reg))
    else $error("status changed by stepping");
  void_read_a: assert property (
    i_rd && self_hit
    |=> o_rd_data == 8'h00 && o_alu_status[`IATP_ALU_ZERO_BIT])
    else $error("self read not zero with flag");
  void_write_a: assert property (
    i_wr && self_hit |=> $stable(state.alu_status_reg) &&
      $stable(state.bank_select_reg) && $stable(state.table_pointer))
    else $error("self write had an effect");
  ind_read_a: assert property (
    i_rd && via_a && !self_hit && eff_addr == `IATP_ADDR_BANK_SEL
    |=> o_rd_data == $past(state.bank_select_reg))
    else $error("indirect read missed target");
  tbl_read_a: assert property (
    i_tbl_op == IATP_TOP_TABLE_READ
    |=> o_pm_rd && o_pm_addr == $past(state.table_pointer)
    ##1 state.table_latch == $past(i_pm_rdata))
    else $error("table read did not fill latch");
  tbl_write_a: assert property (
    i_tbl_op == IATP_TOP_TABLE_WRITE && i_tbl_high
    |=> o_pm_wr && o_pm_wdata[15:8] == $past(i_tbl_byte))
    else $error("table write word wrong");
  rd_one_cycle_a: assert property (
    !i_rd |=> o_rd_data == 8'h00)
    else $error("read data stood too long");
  ptr_a_dec_a: assert property (
    i_rd && via_a && mode_a == 2'b00
    |=> state.data_pointer_a == $past(state.data_pointer_a) - 8'h01)
    else $error("pointer a did not decrement");
  wr_step_a_a: assert property (
    i_wr && via_a && mode_a == 2'b01 && eff_addr != `IATP_ADDR_PTR_A
    |=> state.data_pointer_a == $past(state.data_pointer_a) + 8'h01)
    else $error("pointer a did not step on write");
  wr_step_b_a: assert property (
    i_wr && via_b && mode_b == 2'b00 && eff_addr != `IATP_ADDR_PTR_B
    |=> state.data_pointer_b == $past(state.data_pointer_b) - 8'h01)
    else $error("pointer b did not step on write");
  hold_mode_b_a: assert property (
    access && via_b && mode_b[1] && eff_addr != `IATP_ADDR_PTR_B
    |=> $stable(state.data_pointer_b))
    else $error("pointer b moved in hold mode");
  bank_read_a: assert property (
    i_rd && via_b && eff_addr >= `IATP_ADDR_BANK_LO
    |=> o_rd_data == $past(ram[{state.bank_select_reg[0], eff_addr}]))
    else $error("indirect read took wrong bank");
  zero_ptr_wr_a: assert property (
    i_wr && via_a && state.data_pointer_a == 8'h00
    |=> $stable(state.alu_status_reg) && $stable(state.bank_select_reg))
    else $error("write through zero pointer had an effect");
  zero_ptr_rd_a: assert property (
    i_rd && via_a && state.data_pointer_a == 8'h00
    |=> o_rd_data == 8'h00 && o_alu_status[`IATP_ALU_ZERO_BIT])
    else $error("read through zero pointer not zero");
  wrap_no_flag_a: assert property (
    i_wr && via_a && mode_a == 2'b01 && state.data_pointer_a == 8'hFF
    |=> state.data_pointer_a == 8'h00 && $stable(state.alu_status_reg))
    else $error("wrap to zero touched status");
  tbl_step_a: assert property (
    i_tbl_incr && !i_wr && (i_tbl_op == IATP_TOP_TABLE_READ ||
                            i_tbl_op == IATP_TOP_TABLE_WRITE)
    |=> state.table_pointer == $past(state.table_pointer) + 16'h0001)
    else $error("table pointer did not step");
  tbl_addr_a: assert property (
    i_tbl_op == IATP_TOP_TABLE_WRITE
    |=> o_pm_addr == $past(state.table_pointer))
    else $error("table write address wrong");
  tbl_write_lo_a: assert property (
    i_tbl_op == IATP_TOP_TABLE_WRITE && !i_tbl_high
    |=> o_pm_wr && o_pm_wdata[7:0] == $past(i_tbl_byte))
    else $error("table write low byte wrong");
  latch_rd_a: assert property (
    i_tbl_op == IATP_TOP_LATCH_READ && i_tbl_high
    |=> o_tbl_byte == $past(state.table_latch[15:8]))
    else $error("latch high byte read wrong");

endmodule : iatp_core

// ---- tb_indirect_addressing_table_pointer.sv ----
`include "iatp_map.svh"

module tb_indirect_addressing_table_pointer import iatp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic            clk;
  logic            rst_n;
  logic [7:0]      addr;
  logic [7:0]      wdat;
  logic            wr;
  logic            rd;
  logic [7:0]      rdat;
  iatp_tbl_op_type op;
  logic            hi;
  logic            inc;
  logic [7:0]      tbi;
  logic [7:0]      tbo;
  logic            pm_rd;
  logic            pm_wr;
  logic [15:0]     pm_addr;
  logic [15:0]     pm_wdata;
  logic [15:0]     pm_rdata;
  logic [7:0]      stat;
  integer          fail_count;
  integer          checked;
  integer          cycles;
  integer          seed;
  logic [7:0]      mem [4];
  logic [15:0]     tp;

  iatp_core dut_u (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wr_data(wdat),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rdat), .i_tbl_op(op),
    .i_tbl_high(hi), .i_tbl_incr(inc), .i_tbl_byte(tbi),
    .o_tbl_byte(tbo), .o_pm_rd(pm_rd), .o_pm_wr(pm_wr),
    .o_pm_addr(pm_addr), .o_pm_wdata(pm_wdata), .i_pm_rdata(pm_rdata),
    .o_alu_status(stat)
  );

  // Clock generator, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Closing report
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // Hang guard
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      fail_count = fail_count + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked = checked + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("BAD %0t seen %h expected %h", $time, g, e);
    end
  endtask : chk

  // Expected pointer after one access in the given mode
  function automatic logic [7:0] exp_step(input logic [7:0] p,
                                          input logic [1:0] m);
    if (m[1]) begin
      return p;
    end else if (m[0]) begin
      return p + 8'h01;
    end
    return p - 8'h01;
  endfunction : exp_step

  // One-cycle write strobe
  task automatic bwr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : bwr

  // Read strobe, data looked at in the following cycle only
  task automatic brd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdat, e);
  endtask : brd

  // One-cycle table or latch command
  task automatic top(input iatp_tbl_op_type o, input logic h,
                     input logic n, input logic [7:0] b);
    @(posedge clk);
    op <= o;
    hi <= h;
    inc <= n;
    tbi <= b;
    @(posedge clk);
    op <= IATP_TOP_NONE;
    #1;
  endtask : top

  // Main sequence
  initial begin
    {wr, rd, hi, inc, addr, wdat, tbi, pm_rdata} = '0;
    op = IATP_TOP_NONE;
    fail_count = 0;
    checked = 0;
    cycles = 0;
    seed = 32'hd7fb_5591;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(stat, 16'h00F0);
    brd(`IATP_ADDR_PTR_A, 8'h00);
    brd(8'h07, 8'h00);
    bwr(8'h09, 8'hFF);
    $display("reset test done");
    // Pointer a increments after each write through its port
    bwr(`IATP_ADDR_ALU_STAT, 8'hD0);
    bwr(`IATP_ADDR_PTR_A, 8'h30);
    for (int i = 0; i < 4; i++) begin
      mem[i] = 8'($random(seed));
      bwr(`IATP_ADDR_PORT_A, mem[i]);
    end
    brd(`IATP_ADDR_PTR_A, 8'h34);
    for (int i = 0; i < 4; i++) begin
      brd(8'h30 + 8'(i), mem[i]);
    end
    chk(stat, 16'h00D0);
    // Decrement mode on reads through port a
    bwr(`IATP_ADDR_ALU_STAT, 8'hC0);
    bwr(`IATP_ADDR_PTR_A, 8'h33);
    brd(`IATP_ADDR_PORT_A, mem[3]);
    brd(`IATP_ADDR_PORT_A, mem[2]);
    brd(`IATP_ADDR_PTR_A, 8'h31);
    // Pointer b hold, then decrement from the upper mode pair
    bwr(`IATP_ADDR_PTR_B, 8'h40);
    bwr(`IATP_ADDR_PORT_B, 8'h5A);
    brd(`IATP_ADDR_PTR_B, 8'h40);
    brd(`IATP_ADDR_PORT_B, 8'h5A);
    bwr(`IATP_ADDR_ALU_STAT, 8'h30);
    bwr(`IATP_ADDR_PORT_B, 8'h66);
    brd(`IATP_ADDR_PTR_B, 8'h3F);
    brd(`IATP_ADDR_PTR_A, 8'h31);
    $display("mode test done");
    // Void accesses through a pointer at 00h and at port b
    bwr(`IATP_ADDR_PTR_A, 8'h00);
    bwr(`IATP_ADDR_PORT_A, 8'h77);
    chk(stat, 16'h0030);
    brd(`IATP_ADDR_PORT_A, 8'h00);
    chk(stat, 16'h0034);
    bwr(`IATP_ADDR_ALU_STAT, 8'h30);
    bwr(`IATP_ADDR_PTR_A, `IATP_ADDR_PORT_B);
    bwr(`IATP_ADDR_PORT_A, 8'h99);
    chk(stat, 16'h0030);
    brd(`IATP_ADDR_PORT_A, 8'h00);
    chk(stat, 16'h0034);
    // Wrap to zero leaves the zero flag clear
    bwr(`IATP_ADDR_ALU_STAT, 8'hD0);
    bwr(`IATP_ADDR_PTR_A, 8'hFF);
    bwr(`IATP_ADDR_PORT_A, 8'h11);
    brd(`IATP_ADDR_PTR_A, 8'h00);
    brd(`IATP_ADDR_ALU_STAT, 8'hD0);
    brd(8'hFF, 8'h11);
    $display("void test done");
    // Banked location picked by bank select
    bwr(`IATP_ADDR_BANK_SEL, 8'h00);
    bwr(8'h20, 8'hA1);
    bwr(`IATP_ADDR_BANK_SEL, 8'h01);
    bwr(8'h20, 8'hB2);
    bwr(`IATP_ADDR_PTR_B, 8'h20);
    brd(`IATP_ADDR_PORT_B, 8'hB2);
    bwr(`IATP_ADDR_BANK_SEL, 8'h00);
    brd(`IATP_ADDR_PORT_B, 8'hA1);
    // Pointer b steps up, pointer a holds on the bank select register
    bwr(`IATP_ADDR_ALU_STAT, 8'h70);
    bwr(`IATP_ADDR_BANK_SEL, 8'h5B);
    bwr(`IATP_ADDR_PORT_B, 8'hC7);
    brd(`IATP_ADDR_PTR_B, exp_step(8'h20, 2'b01));
    bwr(`IATP_ADDR_PTR_B, 8'h20);
    brd(`IATP_ADDR_PORT_B, 8'hC7);
    bwr(`IATP_ADDR_PTR_A, `IATP_ADDR_BANK_SEL);
    brd(`IATP_ADDR_PORT_A, 8'h5B);
    brd(`IATP_ADDR_PTR_A, exp_step(`IATP_ADDR_BANK_SEL, 2'b11));
    $display("bank test done");
    // Table read with increment, then latch reads
    tp = 16'($random(seed));
    @(posedge clk);
    pm_rdata <= 16'($random(seed));
    bwr(`IATP_ADDR_TPTR_LO, tp[7:0]);
    bwr(`IATP_ADDR_TPTR_HI, tp[15:8]);
    top(IATP_TOP_TABLE_READ, 1'b0, 1'b1, 8'h00);
    chk(pm_rd, 1'b1);
    chk(pm_addr, tp);
    @(posedge clk);
    #1;
    chk(pm_rd, 1'b0);
    top(IATP_TOP_LATCH_READ, 1'b1, 1'b0, 8'h00);
    chk(tbo, pm_rdata[15:8]);
    top(IATP_TOP_LATCH_READ, 1'b0, 1'b0, 8'h00);
    chk(tbo, pm_rdata[7:0]);
    tp = tp + 16'h0001;
    brd(`IATP_ADDR_TPTR_LO, tp[7:0]);
    brd(`IATP_ADDR_TPTR_HI, tp[15:8]);
    // Latch write high, table write low, whole word goes out
    top(IATP_TOP_LATCH_WRITE, 1'b1, 1'b0, 8'hC3);
    top(IATP_TOP_TABLE_WRITE, 1'b0, 1'b0, 8'h3C);
    chk(pm_wr, 1'b1);
    chk(pm_wdata, 16'hC33C);
    chk(pm_addr, tp);
    // Table write of the high byte with a pointer step
    top(IATP_TOP_TABLE_WRITE, 1'b1, 1'b1, 8'h5A);
    chk(pm_wdata, 16'h5A3C);
    chk(pm_addr, tp);
    tp = tp + 16'h0001;
    brd(`IATP_ADDR_TPTR_LO, tp[7:0]);
    brd(`IATP_ADDR_TPTR_HI, tp[15:8]);
    top(IATP_TOP_LATCH_READ, 1'b1, 1'b0, 8'h00);
    chk(tbo, 8'h5A);
    $display("table test done");
    stop_test();
  end

endmodule : tb_indirect_addressing_table_pointer
